// *** common/ecr_pkg.sv ***
// ecc result report: constants and carrier types
// assumes a 16-bit register read port on the device clock
package ecr_pkg;
    // ************************************************
    // register offsets
    // ************************************************
    localparam logic [15:0] ADDR_STATUS   = 16'hFF00;
    localparam logic [15:0] ADDR_MAIN_1ST = 16'hFF01;
    localparam logic [15:0] ADDR_SPR_1ST  = 16'hFF02;
    localparam logic [15:0] ADDR_MAIN_2ND = 16'hFF03;
    localparam logic [15:0] ADDR_SPR_2ND  = 16'hFF04;
    localparam logic [15:0] ADDR_MAIN_3RD = 16'hFF05;
    localparam logic [15:0] ADDR_SPR_3RD  = 16'hFF06;
    localparam logic [15:0] ADDR_MAIN_4TH = 16'hFF07;
    localparam logic [12:0] ADDR_BLOCK    = 13'h1FE0;
    // ************************************************
    // fields, codes, reset values
    // ************************************************
    localparam int          LANE_LSB      = 0;
    localparam int          WORD_LSB      = 4;
    localparam int          SEL_LSB       = 4;
    localparam int          NUM_MAIN      = 4;
    localparam int          NUM_SPARE_RES = 3;
    localparam logic [1:0]  ST_NONE       = 2'b00;
    localparam logic [1:0]  ST_FIXED      = 2'b01;
    localparam logic [1:0]  ST_UNCORR     = 2'b10;
    localparam logic [1:0]  SEL_WORD2     = 2'b00;
    localparam logic [1:0]  SEL_WORD3_LO  = 2'b01;
    localparam logic [15:0] RST_VALUE     = 16'h0000;
    localparam logic [2:0]  SLOT_LIMIT    = 3'h4;

    typedef enum logic [0:0] {
        LD_IDLE = 1'b0,
        LD_BUSY = 1'b1
    } ecr_load_e;

    // one sector check outcome from the checker
    typedef struct packed {
        logic       spare;
        logic       fail;
        logic       syn_zero;
        logic       par_err;
        logic [7:0] word;
        logic [3:0] lane;
        logic [1:0] sel;
    } ecr_result_s;
endpackage : ecr_pkg

// *** design/ecr_report.sv ***
// ecc result report: status and position registers for page loads
// assumes checker results arrive as single-cycle strobes during a load
`timescale 1ns/1ps

// Overview of operation
// - A nonzero syndrome with parity error is a single error, reported and sent out for correction.
// - Three or more wrong bits are not classified reliably; no extra logic covers them.
// - Main and spare results are counted and stored separately for each sector.
// - A boot load starts a load just like a host load and refreshes the status fields.
// - Status fields use 00 none, 01 corrected, 10 uncorrectable, and never 11.
// - Sector n occupies nibble n with its main field above its spare field.
// - Main fields fill in the order results arrive after the last load start.
// - Four main result registers hold word index 0-255 and lane 0-15.
// - Three spare result registers hold a two-bit word selector and a four-bit lane.
// - Result positions are updated by boot loads as well as host loads.
// - All eight registers are read only and reset to zero.
// - Spare selector 00 is the second word, 01 the third word low byte; others are not produced.
// - A failed sector reads as code 10 in its field.
// - A load ended by reset leaves all status fields at 00.
module ecr_report (
    input  wire logic                CLK_SYS,
    input  wire logic                RESET,
    input  wire logic                LOAD_START,
    input  wire logic                BOOT_START,
    input  wire logic                LOAD_DONE,
    input  wire logic                LOAD_ABORT,
    input  wire logic                RESULT_VALID,
    input  wire ecr_pkg::ecr_result_s RESULT,
    input  wire logic                RD_EN,
    input  wire logic [15:0]         RD_ADDR,
    output logic      [15:0]         RD_DATA_Q,
    output logic                     RD_VALID_Q,
    output logic                     LOAD_ACTIVE_Q,
    output logic                     FIX_VALID_Q,
    output logic                     FIX_SPARE_Q,
    output logic      [7:0]          FIX_WORD_Q,
    output logic      [3:0]          FIX_LANE_Q
);
    // ************************************************
    // classification
    // ************************************************
    function automatic logic [1:0] classify(input ecr_pkg::ecr_result_s r);
        logic [1:0] c;
        c = ecr_pkg::ST_NONE;
        if (r.fail) begin
            c = ecr_pkg::ST_UNCORR;
        end else if (r.par_err) begin
            c = ecr_pkg::ST_FIXED;
        end else if (!r.syn_zero) begin
            c = ecr_pkg::ST_UNCORR;
        end
        return c;
    endfunction : classify

    function automatic logic has_rsv(input logic [15:0] s);
        return (s[1:0] == 2'b11) || (s[3:2] == 2'b11) || (s[5:4] == 2'b11) ||
               (s[7:6] == 2'b11) || (s[9:8] == 2'b11) || (s[11:10] == 2'b11) ||
               (s[13:12] == 2'b11) || (s[15:14] == 2'b11);
    endfunction : has_rsv

    ecr_pkg::ecr_load_e state_q;
    ecr_pkg::ecr_load_e state_d;
    logic [2:0]         main_cnt_q;
    logic [2:0]         spare_cnt_q;
    logic [15:0]        stat_q;
    logic [15:0]        main_res_q [ecr_pkg::NUM_MAIN];
    logic [15:0]        spare_res_q [ecr_pkg::NUM_SPARE_RES];

    wire        start_any = LOAD_START || BOOT_START;
    wire        res_fire  = RESULT_VALID && (state_q == ecr_pkg::LD_BUSY);
    wire [1:0]  res_cls   = classify(RESULT);
    wire        res_fix   = (res_cls == ecr_pkg::ST_FIXED);
    wire        main_ok   = (main_cnt_q < ecr_pkg::SLOT_LIMIT);
    wire        spare_ok  = (spare_cnt_q < ecr_pkg::SLOT_LIMIT);
    wire        main_fire = res_fire && !RESULT.spare && main_ok;
    wire        spr_fire  = res_fire && RESULT.spare && spare_ok;
    wire [1:0]  sel_clean = RESULT.sel[0] ? ecr_pkg::SEL_WORD3_LO : ecr_pkg::SEL_WORD2;
    wire [15:0] main_val  = res_fix ? {4'h0, RESULT.word, RESULT.lane} : ecr_pkg::RST_VALUE;
    wire [15:0] spr_val   = res_fix ? {10'h000, sel_clean, RESULT.lane} : ecr_pkg::RST_VALUE;

    assign state_d = start_any ? ecr_pkg::LD_BUSY :
                     (LOAD_DONE || LOAD_ABORT) ? ecr_pkg::LD_IDLE : state_q;

    // ************************************************
    // load sequencing
    // ************************************************
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state_q <= ecr_pkg::LD_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET || start_any) begin
            main_cnt_q  <= 3'h0;
            spare_cnt_q <= 3'h0;
        end else begin
            if (main_fire) begin
                main_cnt_q <= main_cnt_q + 3'h1;
            end
            if (spr_fire) begin
                spare_cnt_q <= spare_cnt_q + 3'h1;
            end
        end
    end

    // ************************************************
    // status and result registers
    // ************************************************
    genvar gi;
    generate
        for (gi = 0; gi < ecr_pkg::NUM_MAIN; gi++) begin : g_sect
            wire m_hit = main_fire && (main_cnt_q == 3'(gi));
            wire s_hit = spr_fire && (spare_cnt_q == 3'(gi));
            always_ff @(posedge CLK_SYS) begin
                if (RESET || start_any || LOAD_ABORT) begin
                    stat_q[4*gi+3 -: 4] <= 4'h0;
                end else begin
                    if (m_hit) begin
                        stat_q[4*gi+3 -: 2] <= res_cls;
                    end
                    if (s_hit) begin
                        stat_q[4*gi+1 -: 2] <= res_cls;
                    end
                end
            end
            always_ff @(posedge CLK_SYS) begin
                if (RESET || start_any) begin
                    main_res_q[gi] <= ecr_pkg::RST_VALUE;
                end else if (m_hit) begin
                    main_res_q[gi] <= main_val;
                end
            end
            if (gi < ecr_pkg::NUM_SPARE_RES) begin : g_spr
                always_ff @(posedge CLK_SYS) begin
                    if (RESET || start_any) begin
                        spare_res_q[gi] <= ecr_pkg::RST_VALUE;
                    end else if (s_hit) begin
                        spare_res_q[gi] <= spr_val;
                    end
                end
            end
        end
    endgenerate

    // ************************************************
    // correction request toward the buffer memory
    // ************************************************
    wire fix_go = (main_fire || spr_fire) && res_fix;

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            FIX_VALID_Q <= 1'b0;
            FIX_SPARE_Q <= 1'b0;
            FIX_WORD_Q  <= 8'h00;
            FIX_LANE_Q  <= 4'h0;
        end else begin
            FIX_VALID_Q <= fix_go;
            FIX_SPARE_Q <= RESULT.spare;
            FIX_WORD_Q  <= RESULT.spare ? {7'h00, sel_clean[0]} : RESULT.word;
            FIX_LANE_Q  <= RESULT.lane;
        end
    end

    // ************************************************
    // register read port
    // ************************************************
    wire        rd_hit  = (RD_ADDR[15:3] == ecr_pkg::ADDR_BLOCK);
    wire [2:0]  rd_idx  = RD_ADDR[2:0];
    wire [1:0]  rd_pair = rd_idx[2:1];
    wire [1:0]  rd_spr  = rd_pair - 2'h1;
    wire [15:0] rd_mux  = !rd_hit ? ecr_pkg::RST_VALUE :
                          (RD_ADDR == ecr_pkg::ADDR_STATUS) ? stat_q :
                          rd_idx[0] ? main_res_q[rd_pair] :
                          spare_res_q[rd_spr];

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            RD_DATA_Q     <= ecr_pkg::RST_VALUE;
            RD_VALID_Q    <= 1'b0;
            LOAD_ACTIVE_Q <= 1'b0;
        end else begin
            RD_DATA_Q     <= RD_EN ? rd_mux : RD_DATA_Q;
            RD_VALID_Q    <= RD_EN;
            LOAD_ACTIVE_Q <= (state_d == ecr_pkg::LD_BUSY);
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    rsv_code_a: assert property (!has_rsv(stat_q))
        else $error("status field holds reserved code");
    fix_flag_a: assert property (main_fire && res_fix && main_cnt_q == 3'h0 && !start_any && !LOAD_ABORT
        |=> stat_q[3:2] == ecr_pkg::ST_FIXED)
        else $error("corrected error not flagged in first main field");
    fail_code_a: assert property (spr_fire && RESULT.fail && spare_cnt_q == 3'h1 && !start_any && !LOAD_ABORT
        |=> stat_q[5:4] == ecr_pkg::ST_UNCORR)
        else $error("failed sector not flagged uncorrectable");
    abort_clear_a: assert property (LOAD_ABORT |=> stat_q == ecr_pkg::RST_VALUE)
        else $error("status not cleared after aborted load");
    noerr_pos_a: assert property (main_fire && res_cls == ecr_pkg::ST_NONE && main_cnt_q == 3'h1 && !start_any
        |=> main_res_q[1] == ecr_pkg::RST_VALUE)
        else $error("position kept for error-free sector");
    word_pos_a: assert property (main_fire && res_fix && main_cnt_q == 3'h0 && !start_any
        |=> main_res_q[0][11:4] == $past(RESULT.word) && main_res_q[0][3:0] == $past(RESULT.lane))
        else $error("main position not captured");
    spare_sel_a: assert property (spare_res_q[0][15:6] == 10'h000 && spare_res_q[2][5] == 1'b0)
        else $error("spare selector out of range");
    boot_start_a: assert property (BOOT_START |=> LOAD_ACTIVE_Q && main_cnt_q == 3'h0
        && main_res_q[3] == ecr_pkg::RST_VALUE)
        else $error("boot load did not restart reporting");
    rd_zero_a: assert property (RD_EN && !rd_hit |=> RD_VALID_Q && RD_DATA_Q == ecr_pkg::RST_VALUE)
        else $error("unmapped read not zero");
    order_a: assert property (main_fire && !start_any |=> main_cnt_q == $past(main_cnt_q) + 3'h1)
        else $error("main slot did not advance");

    // ************************************************
    // checks on reset, reads, load start and end, main and spare slots, and correction requests
    // ************************************************
    status_rst_a: assert property (
        $fell(RESET)
        |-> stat_q == ecr_pkg::RST_VALUE && RD_DATA_Q == ecr_pkg::RST_VALUE && !FIX_VALID_Q && !LOAD_ACTIVE_Q)
        else $error("state not zero after reset");

    idle_ignore_a: assert property (
        RESULT_VALID && state_q == ecr_pkg::LD_IDLE
        |=> !FIX_VALID_Q)
        else $error("result taken while idle");

    main_none_a: assert property (
        main_fire && res_cls == ecr_pkg::ST_NONE && main_cnt_q == 3'h0 && !start_any && !LOAD_ABORT
        |=> stat_q[3:2] == ecr_pkg::ST_NONE)
        else $error("clean sector not reported as no error");

    spare_pos_a: assert property (
        spr_fire && res_fix && spare_cnt_q == 3'h0 && !start_any
        |=> spare_res_q[0][3:0] == $past(RESULT.lane) && spare_res_q[0][5:4] == $past(sel_clean))
        else $error("spare position not captured");

    start_clear_a: assert property (
        start_any
        |=> stat_q == ecr_pkg::RST_VALUE && main_cnt_q == 3'h0 && spare_cnt_q == 3'h0)
        else $error("load start did not clear status");

    rsv_main_a: assert property (
        main_res_q[0][15:12] == 4'h0 && main_res_q[1][15:12] == 4'h0
        && main_res_q[2][15:12] == 4'h0 && main_res_q[3][15:12] == 4'h0)
        else $error("main result reserved bits set");

    rd_valid_a: assert property (
        RD_EN
        |=> RD_VALID_Q)
        else $error("read not answered");

    rd_status_a: assert property (
        RD_EN && RD_ADDR == ecr_pkg::ADDR_STATUS
        |=> RD_DATA_Q == $past(stat_q))
        else $error("status read mismatch");

    rd_main_a: assert property (
        RD_EN && RD_ADDR == ecr_pkg::ADDR_MAIN_1ST
        |=> RD_DATA_Q == $past(main_res_q[0]))
        else $error("first main result read mismatch");

    fix_lane_a: assert property (
        fix_go
        |=> FIX_VALID_Q && FIX_LANE_Q == $past(RESULT.lane))
        else $error("correction request missing");

    slot_cap_a: assert property (
        main_cnt_q <= ecr_pkg::SLOT_LIMIT
        && spare_cnt_q <= ecr_pkg::SLOT_LIMIT)
        else $error("slot counter past limit");

    uncorr_pos_a: assert property (
        spr_fire && res_cls == ecr_pkg::ST_UNCORR && spare_cnt_q == 3'h2 && !start_any
        |=> spare_res_q[2] == ecr_pkg::RST_VALUE)
        else $error("position kept for uncorrectable spare");

    done_idle_a: assert property (
        LOAD_DONE && !start_any
        |=> !LOAD_ACTIVE_Q)
        else $error("load still active after done");

    abort_keep_a: assert property (
        LOAD_ABORT && !start_any && !res_fire
        |=> main_res_q[0] == $past(main_res_q[0]))
        else $error("aborted load lost main result");

    spare_cnt_a: assert property (
        spr_fire && !start_any
        |=> spare_cnt_q == $past(spare_cnt_q) + 3'h1)
        else $error("spare slot did not advance");

    // ************************************************
    // covers
    // ************************************************
    spare_full_cov_c: cover property (spr_fire && spare_cnt_q == 3'h3);
    fix_cov_c: cover property (main_fire && res_fix ##1 FIX_VALID_Q);
    boot_cov_c: cover property (BOOT_START ##[1:20] spr_fire);
    full_cov_c: cover property (main_fire && main_cnt_q == 3'h3);
    abort_cov_c: cover property (LOAD_ABORT && stat_q != ecr_pkg::RST_VALUE);
endmodule : ecr_report

// *** testbench/ecr_host_model.sv ***
// host model: register reads on the device clock
// assumes the report block answers one cycle after the read strobe
`timescale 1ns/1ps
module ecr_host_model (
    input  wire logic        CLK_SYS,
    output logic             RD_EN,
    output logic [15:0]      RD_ADDR,
    input  wire logic [15:0] RD_DATA_Q,
    input  wire logic        RD_VALID_Q
);
    // ************************************************
    // read cycle
    // ************************************************
    initial begin
        RD_EN   = 1'b0;
        RD_ADDR = 16'h0000;
    end
    task automatic read_reg(input logic [15:0] addr, output logic [15:0] data, output logic vld);
        @(posedge CLK_SYS);
        RD_EN   <= 1'b1;
        RD_ADDR <= addr;
        @(posedge CLK_SYS);
        RD_EN   <= 1'b0;
        RD_ADDR <= ~addr;
        #1;
        data = RD_DATA_Q;
        vld  = RD_VALID_Q;
    endtask : read_reg
endmodule : ecr_host_model

// *** testbench/testbench.sv ***
// testbench: random and corner page loads, then register reads
// assumes report block and host model share one 20 MHz clock
`timescale 1ns/1ps
module testbench;
    // ************************************************
    // signals
    // ************************************************
    logic                 clk_sys = 1'b0;
    logic                 reset = 1'b1;
    logic                 load_start = 1'b0, boot_start = 1'b0, load_done = 1'b0, load_abort = 1'b0;
    logic                 result_valid = 1'b0;
    ecr_pkg::ecr_result_s result = '0;
    ecr_pkg::ecr_result_s r;
    logic                 rd_en, rd_valid_q, load_active_q, fix_valid_q, fix_spare_q;
    logic [15:0]          rd_addr, rd_data_q;
    logic [7:0]           fix_word_q;
    logic [3:0]           fix_lane_q;
    logic [15:0]          exp_reg [0:7];
    logic [31:0]          seed = 32'hbe54_8b45;
    int                   error_cnt = 0, compares = 0, cycles = 0, n_main = 0, n_spare = 0;

    always #25 clk_sys = ~clk_sys;

    ecr_report dut_u (.CLK_SYS(clk_sys), .RESET(reset), .LOAD_START(load_start), .BOOT_START(boot_start),
        .LOAD_DONE(load_done), .LOAD_ABORT(load_abort), .RESULT_VALID(result_valid), .RESULT(result),
        .RD_EN(rd_en), .RD_ADDR(rd_addr), .RD_DATA_Q(rd_data_q), .RD_VALID_Q(rd_valid_q),
        .LOAD_ACTIVE_Q(load_active_q), .FIX_VALID_Q(fix_valid_q), .FIX_SPARE_Q(fix_spare_q),
        .FIX_WORD_Q(fix_word_q), .FIX_LANE_Q(fix_lane_q));
    ecr_host_model host_u (.CLK_SYS(clk_sys), .RD_EN(rd_en), .RD_ADDR(rd_addr), .RD_DATA_Q(rd_data_q),
        .RD_VALID_Q(rd_valid_q));

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [1:0] classify(input ecr_pkg::ecr_result_s x);
        if (x.fail) return ecr_pkg::ST_UNCORR;
        if (x.par_err) return ecr_pkg::ST_FIXED;
        if (!x.syn_zero) return ecr_pkg::ST_UNCORR;
        return ecr_pkg::ST_NONE;
    endfunction : classify
    function automatic ecr_pkg::ecr_result_s rnd(input logic spare);
        ecr_pkg::ecr_result_s x;
        repeat (7) seed = lfsr(seed);
        x = ecr_pkg::ecr_result_s'(seed[17:0]);
        x.spare = spare;
        x.fail = x.fail & seed[20];
        x.sel[1] = 1'b0;
        return x;
    endfunction : rnd
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] want);
        compares++;
        if (seen !== want) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, want, seen);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic check_all;
        logic [15:0] d;
        logic        v;
        for (int i = 0; i < 9; i++) begin
            host_u.read_reg(16'hff00 + 16'(i), d, v);
            chk("rd_valid", {15'h0, v}, 16'h0001);
            chk("register", d, (i < 8) ? exp_reg[i] : 16'h0000);
        end
    endtask : check_all
    task automatic start_load(input logic boot);
        @(posedge clk_sys);
        boot_start <= boot;
        load_start <= !boot;
        @(posedge clk_sys);
        boot_start <= 1'b0;
        load_start <= 1'b0;
        for (int i = 0; i < 8; i++) exp_reg[i] = 16'h0000;
        n_main = 0;
        n_spare = 0;
        #1;
        chk("load_active", {15'h0, load_active_q}, 16'h0001);
    endtask : start_load
    task automatic end_load(input logic abort);
        @(posedge clk_sys);
        load_abort <= abort;
        load_done <= !abort;
        @(posedge clk_sys);
        load_abort <= 1'b0;
        load_done <= 1'b0;
        #1;
        chk("load_active", {15'h0, load_active_q}, 16'h0000);
    endtask : end_load
    task automatic send(input ecr_pkg::ecr_result_s x, input logic take);
        logic [1:0] c;
        int         slot;
        c = classify(x);
        slot = x.spare ? n_spare : n_main;
        take = take && slot < 4;
        @(posedge clk_sys);
        result_valid <= 1'b1;
        result <= x;
        @(posedge clk_sys);
        result_valid <= 1'b0;
        #1;
        chk("fix_valid", {15'h0, fix_valid_q}, {15'h0, take && c == ecr_pkg::ST_FIXED});
        chk("fix_spare", {15'h0, fix_spare_q}, {15'h0, x.spare});
        if (take && c == ecr_pkg::ST_FIXED) begin
            chk("fix_word", {8'h0, fix_word_q}, x.spare ? {15'h0, x.sel[0]} : {8'h0, x.word});
            chk("fix_lane", {12'h0, fix_lane_q}, {12'h0, x.lane});
        end
        if (take) begin
            exp_reg[0][4 * slot + (x.spare ? 0 : 2) +: 2] = c;
            if (c == ecr_pkg::ST_FIXED && !x.spare) exp_reg[2 * slot + 1] = {4'h0, x.word, x.lane};
            if (c == ecr_pkg::ST_FIXED && x.spare && slot < 3) exp_reg[2 * slot + 2] = {10'h0, x.sel, x.lane};
            if (x.spare) n_spare++;
            else n_main++;
        end
    endtask : send

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        for (int i = 0; i < 8; i++) exp_reg[i] = 16'h0000;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        check_all();
        for (int ld = 0; ld < 4; ld++) begin
            start_load(ld[0]);
            for (int k = 0; k < 5; k++) begin
                r = rnd(1'b0);
                if (ld == 0 && k == 0) begin
                    r.fail = 1'b0;
                    r.par_err = 1'b1;
                    r.word = 8'hff;
                    r.lane = 4'hf;
                end
                send(r, 1'b1);
                send(rnd(1'b1), 1'b1);
            end
            end_load(1'b0);
            send(rnd(1'b0), 1'b0);
            check_all();
        end
        start_load(1'b0);
        send(rnd(1'b0), 1'b1);
        send(rnd(1'b1), 1'b1);
        end_load(1'b1);
        exp_reg[0] = 16'h0000;
        check_all();
        start_load(1'b1);
        send(rnd(1'b0), 1'b1);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++) exp_reg[i] = 16'h0000;
        @(posedge clk_sys);
        #1;
        chk("load_active", {15'h0, load_active_q}, 16'h0000);
        chk("fix_valid", {15'h0, fix_valid_q}, 16'h0000);
        check_all();
        tally_and_finish();
    end
endmodule : testbench
